/* File: core/fpc_defines.vh */
/*
 constants for the flyback pulse and protection controller: timing counts at 125 MHz,
 load and valley codes, and fault blanking times.
 assumes an 8 ns clock; times are kept in ns and converted with the macros below.
*/
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH

`define FPC_CLK_NS            8
// least times round up, longest round down
`define FPC_CYC_UP(ns)        (((ns) + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_CYC_DN(ns)        ((ns) / `FPC_CLK_NS)

`define FPC_LEB_NS            160
`define FPC_LEB_CYC           `FPC_CYC_UP(`FPC_LEB_NS)
`define FPC_OC2_WIN_NS        150
`define FPC_OC2_WIN_CYC       `FPC_CYC_DN(`FPC_OC2_WIN_NS)
`define FPC_TOFF_MAX_NS       47000
`define FPC_TOFF_MAX_CYC      `FPC_CYC_DN(`FPC_TOFF_MAX_NS)
`define FPC_HALF_DEF_NS       10000000
`define FPC_HALF_DEF_CYC      `FPC_CYC_DN(`FPC_HALF_DEF_NS)
`define FPC_OVP_BLANK_NS      100000
`define FPC_OVP_BLANK_CYC     `FPC_CYC_UP(`FPC_OVP_BLANK_NS)
`define FPC_OTP_BLANK_NS      18000
`define FPC_OTP_BLANK_CYC     `FPC_CYC_UP(`FPC_OTP_BLANK_NS)
`define FPC_VS_OV_BLANK_NS    20000
`define FPC_VS_OV_BLANK_CYC   `FPC_CYC_UP(`FPC_VS_OV_BLANK_NS)
`define FPC_SUP_BLANK_NS      1000
`define FPC_SUP_BLANK_CYC     `FPC_CYC_UP(`FPC_SUP_BLANK_NS)
`define FPC_RESTART_NS        500000000
`define FPC_RESTART_CYC       `FPC_CYC_DN(`FPC_RESTART_NS)
`define FPC_WAKE_DEF_NS       5000000
`define FPC_WAKE_DEF_CYC      `FPC_CYC_DN(`FPC_WAKE_DEF_NS)

// load current codes in microamps, valley step and maximum, on-time clamp percent
`define FPC_BURST_ENTRY_CODE  10'd560
`define FPC_MIN_LOAD_CODE     10'd610
`define FPC_VALLEY_JUMP       6'd10
`define FPC_VALLEY_MAX        6'd32
`define FPC_PLIM_PCT          7'd85

// jitter half periods: 222 Hz and 266.4 Hz triangles
`define FPC_TRI50_NS          4504504
`define FPC_TRI60_NS          3753753
`define FPC_TRI50_HALF_CYC    `FPC_CYC_DN(`FPC_TRI50_NS / 2)
`define FPC_TRI60_HALF_CYC    `FPC_CYC_DN(`FPC_TRI60_NS / 2)

`endif

/* File: core/fpc_sync.v */
/*
 two flip-flop synchroniser, one per bit of a bus.
 assumes the inputs come from comparators outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module fpc_sync #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta;
   always @(posedge clk) begin
      if (!nrst) begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: core/fpc_qual.v */
/*
 qualification timer: out rises once in has been high for more than LEN cycles.
 assumes in is already synchronised; one instance per blanked comparator.
*/
`timescale 1ns/100ps
`default_nettype none
module fpc_qual #(
   parameter LEN = 20,
   parameter CW  = 16
) (
   input  wire clk,
   input  wire nrst,
   input  wire in,
   output reg  out
);
   reg [CW-1:0] cnt;
   always @(posedge clk) begin
      if (!nrst || !in) begin
         cnt <= {CW{1'b0}};
         out <= 1'b0;
      end else if (cnt >= LEN[CW-1:0]) begin
         out <= 1'b1;
      end else begin
         cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

/* File: core/fpc_ctrl.v */
/*
 pulse generation and protection for a quasi-resonant flyback controller.
 assumes comparator flags and codes from the analog front end; flags pass a synchroniser here, except
 vin_below_plim, vin_at_brownin, dc_input, line_synced and line_is_60hz, which like the codes are taken as stable on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.vh"
module fpc_ctrl #(
   parameter PW          = 16,
   parameter TOFF_CYC    = `FPC_TOFF_MAX_CYC,
   parameter HALF_CYC    = `FPC_HALF_DEF_CYC,
   parameter RESTART_CYC = `FPC_RESTART_CYC,
   parameter WAKE_CYC    = `FPC_WAKE_DEF_CYC,
   parameter OVP_CYC     = `FPC_OVP_BLANK_CYC,
   parameter OTP_CYC     = `FPC_OTP_BLANK_CYC,
   parameter VSOV_CYC    = `FPC_VS_OV_BLANK_CYC,
   parameter TRI50_CYC   = `FPC_TRI50_HALF_CYC,
   parameter TRI60_CYC   = `FPC_TRI60_HALF_CYC
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire          vcc_above_on,
   input  wire          vcc_above_min,
   input  wire          vcc_above_max,
   input  wire          vcc_below_wake,
   input  wire          vcc_above_burst_stop,
   input  wire          cs_above_oc1,
   input  wire          cs_above_oc2,
   input  wire          overtemp,
   input  wire          load_sense_ov,
   input  wire          load_sense_ov_release,
   input  wire          zero_crossing_pin,
   input  wire          demag,
   input  wire          vin_below_plim,
   input  wire          vin_at_brownin,
   input  wire          dc_input,
   input  wire          line_half_edge,
   input  wire          line_synced,
   input  wire          line_is_60hz,
   input  wire [9:0]    load_code,
   input  wire [5:0]    mapped_valley,
   input  wire [7:0]    mapped_duty,
   input  wire [PW-1:0] pulse_len,
   output reg           gate_drive_output,
   output reg           startup_pullup_en,
   output reg           quasi_resonant_mode,
   output reg           fault_restart,
   output reg           overcurrent_level_two,
   output reg           switching_blocked,
   output reg  [5:0]    valley_count
);
   localparam ST_OFF   = 3'd0;
   localparam ST_WAIT  = 3'd1;
   localparam ST_ON    = 3'd2;
   localparam ST_FAULT = 3'd3;
   localparam ST_PAUSE = 3'd4;

   // synchronised comparator flags
   wire [11:0] raw = {zero_crossing_pin, demag, line_half_edge, vcc_above_on, vcc_above_min,
                      vcc_above_max, vcc_below_wake, vcc_above_burst_stop, cs_above_oc1,
                      cs_above_oc2, overtemp, load_sense_ov};
   wire [11:0] sy;
   fpc_sync #(.W(12)) u_sync (.clk(clk), .nrst(nrst), .d(raw), .q(sy));
   wire s_zcd   = sy[11];
   wire s_demag = sy[10];
   wire s_half  = sy[9];
   wire s_on    = sy[8];
   wire s_min   = sy[7];
   wire s_wake  = sy[5];
   wire s_bstop = sy[4];
   wire s_oc1   = sy[3];
   wire s_oc2   = sy[2];
   reg          s_rel;
   reg          s_rel_m;

   wire q_vmax;
   wire q_otp;
   wire q_vsov;
   wire q_ovp;
   fpc_qual #(.LEN(`FPC_SUP_BLANK_CYC), .CW(16)) u_qvmax (
      .clk(clk), .nrst(nrst), .in(sy[6]), .out(q_vmax));
   fpc_qual #(.LEN(OTP_CYC), .CW(16)) u_qotp (
      .clk(clk), .nrst(nrst), .in(sy[1]), .out(q_otp));
   fpc_qual #(.LEN(VSOV_CYC), .CW(16)) u_qvsov (
      .clk(clk), .nrst(nrst), .in(sy[0]), .out(q_vsov));
   fpc_qual #(.LEN(OVP_CYC), .CW(16)) u_qovp (
      .clk(clk), .nrst(nrst), .in(s_oc1 & s_demag), .out(q_ovp));

   reg  [2:0]    state;
   reg  [2:0]    next_state;
   reg  [PW-1:0] tcnt;
   reg  [31:0]   rcnt;
   reg  [31:0]   half_cnt;
   reg  [31:0]   half_len;
   reg  [5:0]    vcnt;
   reg  [5:0]    lowest;
   reg           zcd_d;
   reg           half_d;
   reg           uvlo_ok;
   reg           vs_block;
   reg           wake_burst;
   reg  [31:0]   wake_cnt;
   reg  [31:0]   burst_len;
   reg  [31:0]   burst_cnt;
   reg           burst_active;
   reg           wake_evt_r;
   reg  [7:0]    oc1_cnt;
   reg  [7:0]    oc2_win;
   reg  [31:0]   tri_cnt;
   reg           tri_up;
   reg  [PW-1:0] jit;

   wire zcd_fall  = zcd_d & ~s_zcd;
   wire half_tick = (s_half & ~half_d) | (~line_synced & (half_cnt >= half_len));
   wire hard_fault = overcurrent_level_two | q_vmax | q_otp | q_ovp;
   wire burst_sel  = load_code >= `FPC_BURST_ENTRY_CODE;

   // on-time limit: full length or 85 percent clamp
   wire [PW+6:0] plim_prod = pulse_len * `FPC_PLIM_PCT;
   wire [PW+6:0] plim_quo  = plim_prod / 7'd100;
   wire [PW-1:0] plim_len  = plim_quo[PW-1:0];
   wire [PW-1:0] base_on   = (vin_at_brownin & ~vin_below_plim) ? plim_len
                                                               : pulse_len;
   wire [PW-1:0] on_len    = dc_input ? base_on - jit : base_on;
   wire [31:0]   tri_half  = line_is_60hz ? TRI60_CYC[31:0] : TRI50_CYC[31:0];
   wire          on_done   = ({1'b0, tcnt} + {{PW{1'b0}}, 1'b1}) >= {1'b0, on_len};

   // synchroniser for release comparator, kept with its user
   always @(posedge clk) begin
      if (!nrst) begin
         s_rel_m <= 1'b0;
         s_rel   <= 1'b0;
      end else begin
         s_rel_m <= load_sense_ov_release;
         s_rel   <= s_rel_m;
      end
   end

   // supply lockout and load-sense block
   always @(posedge clk) begin
      if (!nrst) begin
         uvlo_ok  <= 1'b0;
         vs_block <= 1'b0;
      end else begin
         if (!s_min)
            uvlo_ok <= 1'b0;
         else if (s_on)
            uvlo_ok <= 1'b1;
         if (q_vsov)
            vs_block <= 1'b1;
         else if (s_rel)
            vs_block <= 1'b0;
      end
   end

   // jitter triangle
   always @(posedge clk) begin
      if (!nrst || !dc_input) begin
         tri_cnt <= 32'h0;
         tri_up  <= 1'b1;
         jit     <= {PW{1'b0}};
      end else begin
         if (tri_cnt >= tri_half) begin
            tri_cnt <= 32'h0;
            tri_up  <= ~tri_up;
         end else begin
            tri_cnt <= tri_cnt + 32'h1;
         end
         if (tri_cnt[9:0] == 10'h0) begin
            if (tri_up && jit < (base_on >> 3))
               jit <= jit + {{(PW-1){1'b0}}, 1'b1};
            else if (!tri_up && jit != {PW{1'b0}})
               jit <= jit - {{(PW-1){1'b0}}, 1'b1};
         end
      end
   end

   // valley selection and half-cycle timing
   always @(posedge clk) begin
      if (!nrst) begin
         half_d       <= 1'b0;
         half_cnt     <= 32'h0;
         half_len     <= HALF_CYC;
         lowest       <= `FPC_VALLEY_MAX;
         valley_count <= 6'h1;
      end else begin
         half_d <= s_half;
         if (half_tick) begin
            half_cnt <= 32'h0;
            if (line_synced)
               half_len <= half_cnt;
         end else begin
            half_cnt <= half_cnt + 32'h1;
         end
         if (burst_sel) begin
            if (wake_evt_r)
               valley_count <= mapped_valley;
            lowest <= `FPC_VALLEY_MAX;
         end else if (half_tick) begin
            valley_count <= (mapped_valley < lowest) ? mapped_valley : lowest;
            lowest       <= `FPC_VALLEY_MAX;
         end else begin
            if (mapped_valley < lowest)
               lowest <= mapped_valley;
            if (mapped_valley < valley_count)
               valley_count <= mapped_valley;
            else if ({1'b0, mapped_valley} >= {1'b0, valley_count} + {1'b0, `FPC_VALLEY_JUMP})
               valley_count <= mapped_valley;
         end
      end
   end

   // burst wake schedule
   always @(posedge clk) begin
      if (!nrst) begin
         wake_cnt     <= 32'h0;
         wake_evt_r   <= 1'b0;
         wake_burst   <= 1'b0;
         burst_active <= 1'b0;
         burst_len    <= 32'h0;
         burst_cnt    <= 32'h0;
         startup_pullup_en <= 1'b1;
      end else begin
         wake_evt_r <= 1'b0;
         if (!burst_sel) begin
            wake_cnt     <= 32'h0;
            wake_burst   <= 1'b0;
            burst_active <= 1'b0;
            startup_pullup_en <= 1'b1;
         end else begin
            if (s_wake) begin
               wake_burst   <= 1'b1;
               burst_active <= 1'b1;
               wake_cnt     <= 32'h0;
               startup_pullup_en <= 1'b0;
            end else if (wake_burst) begin
               if (s_bstop) begin
                  wake_burst   <= 1'b0;
                  burst_active <= 1'b0;
                  startup_pullup_en <= 1'b1;
               end
            end else if (wake_cnt >= WAKE_CYC) begin
               wake_cnt   <= 32'h0;
               wake_evt_r <= 1'b1;
               burst_cnt  <= 32'h0;
               // pulsing time = duty/256 of the wake interval
               burst_len    <= (WAKE_CYC >> 8) * {24'h0, mapped_duty};
               burst_active <= (load_code < `FPC_MIN_LOAD_CODE);
            end else begin
               wake_cnt <= wake_cnt + 32'h1;
               if (burst_active) begin
                  burst_cnt <= burst_cnt + 32'h1;
                  if (burst_cnt >= burst_len)
                     burst_active <= 1'b0;
               end
            end
         end
      end
   end

   // switching state machine
   always @* begin
      next_state = state;
      case (state)
         ST_OFF:   if (uvlo_ok) next_state = ST_WAIT;
         ST_WAIT: begin
            if (!burst_sel || burst_active) begin
               if ({1'b0, vcnt} + 7'h1 >= {1'b0, valley_count} && zcd_fall)
                  next_state = ST_ON;
               else if (tcnt >= TOFF_CYC[PW-1:0])
                  next_state = ST_ON;
            end
         end
         ST_ON:    if (on_done || oc1_cnt >= `FPC_LEB_CYC) next_state = ST_WAIT;
         ST_FAULT: if (rcnt >= RESTART_CYC) next_state = ST_OFF;
         default:  next_state = ST_OFF;
      endcase
      if (hard_fault && state != ST_FAULT)
         next_state = ST_FAULT;
      else if (!uvlo_ok)
         next_state = ST_OFF;
      else if (vs_block && state == ST_ON)
         next_state = ST_WAIT;
   end

   always @(posedge clk) begin
      if (!nrst) begin
         state   <= ST_OFF;
         tcnt    <= {PW{1'b0}};
         rcnt    <= 32'h0;
         vcnt    <= 6'h0;
         zcd_d   <= 1'b0;
         oc1_cnt <= 8'h0;
         oc2_win <= 8'h0;
         overcurrent_level_two <= 1'b0;
      end else begin
         state <= next_state;
         zcd_d <= s_zcd;
         if (next_state != state) begin
            tcnt <= {PW{1'b0}};
            vcnt <= 6'h0;
         end else begin
            if (tcnt != {PW{1'b1}})
               tcnt <= tcnt + {{(PW-1){1'b0}}, 1'b1};
            if (zcd_fall && vcnt != 6'h3f)
               vcnt <= vcnt + 6'h1;
         end
         rcnt <= (state == ST_FAULT) ? rcnt + 32'h1 : 32'h0;
         oc1_cnt <= (state == ST_ON && s_oc1) ? oc1_cnt + 8'h1 : 8'h0;
         if (!s_oc1)
            oc2_win <= 8'h0;
         else if (oc2_win != 8'hff)
            oc2_win <= oc2_win + 8'h1;
         if (state == ST_FAULT && next_state == ST_OFF)
            overcurrent_level_two <= 1'b0;
         else if (state == ST_ON && s_oc2 && s_oc1 && oc2_win <= `FPC_OC2_WIN_CYC)
            overcurrent_level_two <= 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         gate_drive_output   <= 1'b0;
         quasi_resonant_mode <= 1'b1;
         fault_restart       <= 1'b0;
         switching_blocked   <= 1'b0;
      end else begin
         gate_drive_output   <= (next_state == ST_ON) && !vs_block;
         quasi_resonant_mode <= ~burst_sel;
         fault_restart       <= (next_state == ST_FAULT);
         switching_blocked   <= vs_block;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/fpc_stage_model.sv */
/*
 behavioural flyback power stage: current sense, demagnetisation and valley ringing.
 assumes the bench sets oc_at and oc2_en; outputs change on the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module fpc_stage_model (
   input  wire logic       clk,
   input  wire logic       gate_drive_output,
   input  wire logic [7:0] oc_at,
   input  wire logic       oc2_en,
   output var  logic       cs_above_oc1,
   output var  logic       cs_above_oc2,
   output var  logic       demag,
   output var  logic       zero_crossing_pin
);
   int on_cnt = 0;
   int off_cnt = 1000;
   initial begin
      cs_above_oc1 = 1'b0;
      cs_above_oc2 = 1'b0;
      demag = 1'b0;
      zero_crossing_pin = 1'b0;
   end
   always @(negedge clk) begin
      on_cnt <= (gate_drive_output === 1'b1) ? on_cnt + 1 : 0;
      off_cnt <= (gate_drive_output === 1'b1) ? 0 : off_cnt + 1;
      // sense crosses the first level only while the switch conducts
      cs_above_oc1 <= gate_drive_output === 1'b1 && oc_at != 0 && on_cnt >= oc_at;
      cs_above_oc2 <= oc2_en && cs_above_oc1 && gate_drive_output === 1'b1;
      // reflected output stays below the overvoltage level during demag
      demag <= gate_drive_output !== 1'b1 && off_cnt < 6;
      zero_crossing_pin <= off_cnt >= 6 && off_cnt < 40 && off_cnt[1];
   end
endmodule
`default_nettype wire

/* File: testbench/fpc_chk_assertions.sv */
/*
 checker for the pulse and protection controller.
 assumes it is bound to fpc_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module fpc_chk #(
   parameter VSOV_CYC = 10
) (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       vcc_above_min,
   input wire logic       vcc_below_wake,
   input wire logic       cs_above_oc1,
   input wire logic       load_sense_ov,
   input wire logic       gate_drive_output,
   input wire logic       startup_pullup_en,
   input wire logic       quasi_resonant_mode,
   input wire logic       fault_restart,
   input wire logic       overcurrent_level_two,
   input wire logic       switching_blocked,
   input wire logic [5:0] valley_count
);
   int oc1_cnt;
   int vsov_cnt;
   always @(posedge clk) begin
      if (!nrst) begin
         oc1_cnt <= 0;
         vsov_cnt <= 0;
      end else begin
         oc1_cnt <= cs_above_oc1 ? oc1_cnt + 1 : 0;
         vsov_cnt <= load_sense_ov ? vsov_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_fault_held;
      fault_restart [*2];
   endsequence
   sequence s_block_held;
      switching_blocked [*2];
   endsequence
   sequence s_wake_held;
      (vcc_below_wake && !quasi_resonant_mode && !fault_restart) [*4];
   endsequence
   a_fault_gate_off: assert property (s_fault_held |-> !gate_drive_output)
      else $error("gate high during restart delay");
   a_block_gate_off: assert property (s_block_held |-> !gate_drive_output)
      else $error("gate high while load sense blocks");
   a_lockout_gate_off: assert property (!vcc_above_min [*6] |-> !gate_drive_output)
      else $error("gate high under lockout");
   a_oc1_cuts_gate: assert property (oc1_cnt >= 23 |-> !gate_drive_output)
      else $error("gate not cut after overcurrent blanking");
   a_oc2_restart: assert property ($rose(overcurrent_level_two) |-> ##[0:2] fault_restart)
      else $error("second overcurrent without restart");
   a_restart_ends: assert property ($rose(fault_restart) |-> ##[1:12] !fault_restart)
      else $error("restart delay too long");
   a_block_qualified: assert property ($rose(switching_blocked) |-> vsov_cnt >= VSOV_CYC)
      else $error("block before qualification time");
   a_wake_pullup_off: assert property (s_wake_held |-> !startup_pullup_en)
      else $error("pull-up still on at supply wake");
   a_valley_in_range: assert property (valley_count >= 6'd1 && valley_count <= 6'd32)
      else $error("valley count out of range");
endmodule
bind fpc_ctrl fpc_chk #(.VSOV_CYC(VSOV_CYC)) u_fpc_chk (.clk, .nrst, .vcc_above_min,
   .vcc_below_wake, .cs_above_oc1, .load_sense_ov, .gate_drive_output, .startup_pullup_en,
   .quasi_resonant_mode, .fault_restart, .overcurrent_level_two, .switching_blocked,
   .valley_count);
`default_nettype wire

/* File: testbench/tb.sv */
/*
 self-checking bench for the pulse and protection controller with a power stage model.
 assumes shortened delay parameters and an 8 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fpc_defines.vh"
module tb;
   logic        clk, nrst, vcc_above_on, vcc_above_min, vcc_above_max, vcc_below_wake;
   logic        vcc_above_burst_stop, overtemp, load_sense_ov, load_sense_ov_release;
   logic        vin_below_plim, vin_at_brownin, dc_input, line_synced, line_is_60hz, oc2_en;
   logic        line_half_edge = 1'b0;
   logic [9:0]  load_code;
   logic [5:0]  mapped_valley;
   logic [7:0]  mapped_duty, oc_at;
   logic [15:0] pulse_len;
   logic [7:0]  rnd = 8'h1a;
   wire logic   cs_above_oc1, cs_above_oc2, demag, zero_crossing_pin, gate_drive_output;
   wire logic   startup_pullup_en, quasi_resonant_mode, fault_restart, overcurrent_level_two;
   wire logic   switching_blocked;
   wire logic [5:0] valley_count;
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          hcnt = 0;
   int          w, c, lo, hi, pl;

   fpc_ctrl #(.RESTART_CYC(8), .WAKE_CYC(2560), .TOFF_CYC(50), .TRI50_CYC(100),
      .TRI60_CYC(100)) dut (.clk, .nrst,
      .vcc_above_on, .vcc_above_min, .vcc_above_max, .vcc_below_wake, .vcc_above_burst_stop,
      .cs_above_oc1, .cs_above_oc2, .overtemp, .load_sense_ov, .load_sense_ov_release,
      .zero_crossing_pin, .demag, .vin_below_plim, .vin_at_brownin, .dc_input,
      .line_half_edge, .line_synced, .line_is_60hz, .load_code, .mapped_valley, .mapped_duty,
      .pulse_len, .gate_drive_output, .startup_pullup_en, .quasi_resonant_mode,
      .fault_restart, .overcurrent_level_two, .switching_blocked, .valley_count);
   fpc_stage_model stage (.clk, .gate_drive_output, .oc_at, .oc2_en, .cs_above_oc1,
      .cs_above_oc2, .demag, .zero_crossing_pin);

   always #4 clk = ~clk;
   always @(negedge clk) begin
      hcnt <= (hcnt == 149) ? 0 : hcnt + 1;
      line_half_edge <= (hcnt == 0);
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic pick(input int s);
      case (s)
         0: return fault_restart;
         1: return overcurrent_level_two;
         2: return switching_blocked;
         3: return quasi_resonant_mode;
         default: return startup_pullup_en;
      endcase
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input int l, input int h, input logic [31:0] got);
      check_count++;
      if (^got === 1'bx || got < l || got > h) begin
         fails++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, l, h, got);
      end
   endtask
   task automatic wait_for(input string what, input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(what, v, v, {31'd0, pick(s)});
   endtask
   task automatic meas(output int wd);
      int n;
      n = 0;
      wd = 0;
      // let a pulse already under way end, so only whole pulses are measured
      while (gate_drive_output === 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      while (gate_drive_output !== 1'b1 && n < 800) begin
         @(negedge clk);
         n++;
      end
      while (gate_drive_output === 1'b1 && wd < 400) begin
         @(negedge clk);
         wd++;
      end
   endtask
   task automatic count_high(input int len, output int cnt);
      cnt = 0;
      repeat (len) begin
         @(negedge clk);
         if (gate_drive_output !== 1'b0)
            cnt++;
      end
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         give_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      {vcc_above_on, vcc_above_min, vcc_above_burst_stop, line_synced} = 4'hf;
      {vcc_above_max, vcc_below_wake, overtemp, load_sense_ov, load_sense_ov_release} = 5'h0;
      {vin_below_plim, vin_at_brownin, dc_input, line_is_60hz, oc2_en} = 5'h0;
      load_code = 10'h000;
      mapped_valley = 6'h01;
      mapped_duty = 8'h80;
      oc_at = 8'h00;
      pulse_len = 16'h0040;
      repeat (10) @(negedge clk);
      chk("reset_gate", 0, 0, {31'd0, gate_drive_output});
      chk("reset_valley", 1, 1, {26'd0, valley_count});
      nrst = 1'b1;
      // full length, brownin clamp, then jitter with dc input
      for (int m = 0; m < 3; m++) begin
         rnd = lfsr(rnd);
         pl = 40 + rnd[5:0];
         pulse_len = pl[15:0];
         mapped_valley = 6'd1 + {4'd0, rnd[1:0]};
         mapped_duty = rnd;
         line_is_60hz = rnd[2];
         vin_below_plim = (m != 1);
         vin_at_brownin = (m == 1);
         dc_input = (m == 2);
         lo = (m == 1) ? pl * `FPC_PLIM_PCT / 100 - 1 : (m == 2 ? pl - pl / 8 - 1 : pl);
         hi = (m == 1) ? lo + 2 : (m == 2 ? pl + pl / 8 + 1 : pl);
         repeat (300) @(negedge clk);
         for (int k = 0; k < 3; k++) begin
            meas(w);
            chk("pulse_width", lo, hi, w);
         end
      end
      dc_input = 1'b0;
      vin_below_plim = 1'b1;
      vin_at_brownin = 1'b0;
      pulse_len = 16'd100;
      $display("test pulse_length done");
      oc_at = 8'd5;
      meas(w);
      meas(w);
      chk("oc1_cut_width", 24, 34, w);
      chk("oc1_no_fault", 0, 0, {31'd0, fault_restart});
      oc2_en = 1'b1;
      wait_for("oc2_flag", 1, 1'b1, 300);
      wait_for("oc2_restart", 0, 1'b1, 5);
      oc_at = 8'd0;
      oc2_en = 1'b0;
      wait_for("restart_end", 0, 1'b0, 40);
      chk("oc2_cleared", 0, 0, {31'd0, overcurrent_level_two});
      $display("test overcurrent done");
      for (int i = 0; i < 2; i++) begin
         {overtemp, vcc_above_max} = (i == 0) ? 2'b01 : 2'b10;
         wait_for("hard_fault", 0, 1'b1, 2400);
         {overtemp, vcc_above_max} = 2'b00;
         wait_for("fault_end", 0, 1'b0, 40);
      end
      $display("test hard_faults done");
      load_sense_ov = 1'b1;
      wait_for("ls_block", 2, 1'b1, 2600);
      count_high(200, c);
      chk("ls_gate_idle", 0, 0, c);
      load_sense_ov = 1'b0;
      load_sense_ov_release = 1'b1;
      wait_for("ls_release", 2, 1'b0, 40);
      $display("test load_sense done");
      load_code = `FPC_BURST_ENTRY_CODE + 10'd40;
      wait_for("burst_entry", 3, 1'b0, 3000);
      vcc_below_wake = 1'b1;
      vcc_above_burst_stop = 1'b0;
      wait_for("wake_pullup_off", 4, 1'b0, 3000);
      vcc_below_wake = 1'b0;
      vcc_above_burst_stop = 1'b1;
      load_code = `FPC_MIN_LOAD_CODE + 10'd10;
      repeat (2600) @(negedge clk);
      count_high(2600, c);
      chk("burst_skip", 0, 0, c);
      load_code = 10'd0;
      wait_for("qr_return", 3, 1'b1, 3000);
      $display("test burst done");
      {vcc_above_on, vcc_above_min} = 2'b00;
      repeat (10) @(negedge clk);
      count_high(200, c);
      chk("lockout_idle", 0, 0, c);
      {vcc_above_on, vcc_above_min} = 2'b11;
      meas(w);
      chk("restart_pulse", 1, 100, w);
      $display("test lockout done");
      give_verdict();
   end
endmodule
`default_nettype wire
